//--- inc/dte_disc_consts.svh
`ifndef DTE_DISC_CONSTS_SVH
`define DTE_DISC_CONSTS_SVH
// register map
`define REG_DISC_CS 5'h1B
`define BIT_DISC_EN 6
`define BIT_POWER_FOUND 4
`define BIT_PLAIN_SEEN 3
`define BIT_INHIBIT_LAPSED 2
// page layout
`define PG_NP 15
`define PG_ACK 14
`define PG_MP 13
`define PG_TOG 11
`define MSG_CODE_OUI 11'h005
`define NUM_PAGES 5
// generator
`define LFSR_W 11
`endif

//--- inc/dte_disc_pkg.sv
package dte_disc_pkg;
  typedef enum logic [1:0] {act_none, act_nlp, act_mlt3, act_flp} line_act_e;
  // received page from the base negotiation engine
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } page_s;
  // events from the base negotiation engine
  typedef struct packed {
    logic an_restart;
    logic link_up;
    logic an_complete;
    logic par_detect;
    logic inhibit_expired;
  } an_evt_s;
  // management register access strobes
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_s;
endpackage

//--- logic/dte_discovery.sv
// How it works
// [R1] discovery only with both enables set
// [R2] base page advertises next page ability
// [R3] classify line activity, check partner ability
// [R4] partner next page: send message five sequence
// [R5] message page fixed layout, code five
// [R6] user pages one, two carry identifier bits
// [R7] user pages three, four carry random bits
// [R8] generator seeded from port address
// [R9] pages fixed, transmit register ignored
// [R10] echo matching in bits 10:0 and MP on every page sets power found flag
// [R11] resend final page until restart
// [R12] power found clears on restart, disable
// [R13] interrupted discovery leaves power flag zero
// [R14] enable bit sticky until software clears
// [R15] link already up: wait for drop
// [R16] plain partner flag on non matching activity
// [R17] plain partner flag clear conditions
// [R18] inhibit lapsed flag, same clears
// [R19] on inhibit expiry restart chosen mode
// [R20] per port bits over management interface
// [R21] software polls, powers, then restarts
// [R22] software times out cable power
// [R23] software watches link, removes power
// [R24] eleven bit lfsr, nonzero address seed
`timescale 1ns/100ps
`include "dte_disc_consts.svh"
`default_nettype none
module dte_discovery
#(
  parameter int LFSR_W = `LFSR_W
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // static configuration
  input wire logic [4:0] port_addr,
  input wire logic [15:0] phy_id2,
  input wire logic [15:0] phy_id3,
  input wire logic an_enable,
  // negotiation engine side
  input wire dte_disc_pkg::line_act_e line_act,
  input wire logic partner_np_able,
  input wire dte_disc_pkg::page_s rx_page,
  input wire logic tx_page_taken,
  input wire dte_disc_pkg::an_evt_s an_evt,
  // management access
  input wire dte_disc_pkg::mgmt_s mgmt,
  output logic [15:0] mgmt_rdata,
  // toward the negotiation engine
  output logic adv_np_able,
  output logic [15:0] tx_page,
  output logic tx_page_valid,
  output logic restart_with_disc,
  output logic restart_plain_an,
  output logic restart_forced
);
  import dte_disc_pkg::*;

  // discovery engine states
  typedef enum logic [2:0] {st_idle, st_wait_down, st_listen, st_send,
                            st_check, st_found, st_done} disc_e;

  // page word builder, shared by transmit and compare
  function automatic logic [15:0] build_page(input logic [2:0] idx,
    input logic [15:0] id2, input logic [15:0] id3,
    input logic [LFSR_W-1:0] rnd);
    logic [10:0] body;
    logic [15:0] w;
    body = 11'h000;
    case (idx)
      3'd0: body = `MSG_CODE_OUI;
      3'd1: body = {id3[10], id3[11], id3[12], id3[13], id3[14], id3[15],
                    id2[0], id2[1], id2[2], id2[3], id2[4]};
      3'd2: body = {id2[5], id2[6], id2[7], id2[8], id2[9], id2[10],
                    id2[11], id2[12], id2[13], id2[14], id2[15]};
      3'd3: body = {2'b00, rnd[8:0]};
      3'd4: body = rnd[10:0];
      default: body = 11'h000;
    endcase
    w = {5'h00, body};
    w[`PG_NP] = 1'b1;
    w[`PG_MP] = (idx == 3'd0);
    return w;
  endfunction

  disc_e st_r, st_nxt;
  logic [LFSR_W-1:0] lfsr_r, lfsr_nxt, snap_r, snap_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic tog_r, tog_nxt;
  logic en_r, en_nxt, pwr_r, pwr_nxt, plain_r, plain_nxt;
  logic lapsed_r, lapsed_nxt;
  logic [15:0] rdata_r, rdata_nxt, txp_r, txp_nxt;
  logic txv_r, txv_nxt, adv_r, adv_nxt;
  logic rs_disc_r, rs_disc_nxt, rs_an_r, rs_an_nxt, rs_f_r, rs_f_nxt;
  logic active, reg_hit, rd_hit, flag_clr;
  logic [15:0] expect_w;

  assign active = en_r && an_enable; // R1
  assign reg_hit = (mgmt.addr == `REG_DISC_CS);
  assign rd_hit = mgmt.rd && reg_hit;
  // common clear of the two sticky flags
  assign flag_clr = !en_r || an_evt.link_up || an_evt.an_restart
                    || !an_enable; // R17
  assign expect_w = build_page(idx_r, phy_id2, phy_id3, snap_r); // R10

  // next state of discovery engine and status
  always_comb
  begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    tog_nxt = tog_r;
    snap_nxt = snap_r;
    en_nxt = en_r;
    pwr_nxt = pwr_r;
    plain_nxt = plain_r;
    lapsed_nxt = lapsed_r;
    txp_nxt = txp_r;
    txv_nxt = txv_r;
    rs_disc_nxt = 1'b0;
    rs_an_nxt = 1'b0;
    rs_f_nxt = 1'b0;
    if (mgmt.wr && reg_hit)
      en_nxt = mgmt.wdata[`BIT_DISC_EN]; // R14 R20
    adv_nxt = active; // R2
    // sticky flags: clear first, events below win
    if (rd_hit || flag_clr)
    begin
      plain_nxt = 1'b0; // R17
      lapsed_nxt = 1'b0; // R18
    end
    if (an_evt.an_restart || !an_enable)
      pwr_nxt = 1'b0; // R12
    case (st_r)
      st_idle:
        if (active)
          st_nxt = an_evt.link_up ? st_wait_down : st_listen; // R15
      st_wait_down:
        if (!active)
          st_nxt = st_idle;
        else if (!an_evt.link_up)
          st_nxt = st_listen; // R15
      st_listen:
        if (!active)
          st_nxt = st_idle;
        else if (an_evt.an_complete || an_evt.par_detect)
          st_nxt = st_done; // R13
        else if (line_act == act_nlp || line_act == act_mlt3 ||
                 (line_act == act_flp && !partner_np_able))
        begin
          plain_nxt = 1'b1; // R16 R3
          st_nxt = st_done;
        end
        else if (line_act == act_flp && partner_np_able)
        begin
          snap_nxt = lfsr_r; // R4 R8
          idx_nxt = 3'd0;
          tog_nxt = 1'b0;
          st_nxt = st_send;
        end
      st_send:
      begin
        // fixed pages; transmit register never consulted
        txp_nxt = build_page(idx_r, phy_id2, phy_id3, snap_r); // R9 R5 R6 R7
        txp_nxt[`PG_TOG] = tog_r;
        txp_nxt[`PG_ACK] = 1'b1;
        txv_nxt = 1'b1;
        st_nxt = st_check;
      end
      st_check:
        if (!active || an_evt.an_complete || an_evt.par_detect)
        begin
          txv_nxt = 1'b0; // R13
          st_nxt = active ? st_done : st_idle;
        end
        else if (rx_page.valid)
        begin
          if (rx_page.word[10:0] != expect_w[10:0] ||
              rx_page.word[`PG_MP] != expect_w[`PG_MP])
          begin
            plain_nxt = 1'b1; // R16
            txv_nxt = 1'b0;
            st_nxt = st_done;
          end
          else if (idx_r == 3'(`NUM_PAGES - 1))
          begin
            pwr_nxt = 1'b1; // R10
            st_nxt = st_found;
          end
          else if (tx_page_taken || 1'b1)
          begin
            idx_nxt = idx_r + 3'd1;
            tog_nxt = !tog_r;
            st_nxt = st_send;
          end
        end
      st_found:
        // last page stays on the line
        if (an_evt.an_restart || !an_enable)
        begin
          txv_nxt = 1'b0; // R11
          st_nxt = st_idle;
        end
      st_done:
        if (an_evt.an_restart || !active)
          st_nxt = st_idle;
        else if (an_evt.inhibit_expired && !an_evt.link_up)
        begin
          lapsed_nxt = 1'b1; // R18
          st_nxt = st_idle;
        end
        else if (an_evt.link_up)
          st_nxt = st_wait_down;
      default:
        st_nxt = st_idle;
    endcase
    // restart choice on inhibit expiry
    if (an_evt.inhibit_expired && !an_evt.link_up && st_r != st_found)
    begin
      rs_disc_nxt = active; // R19
      rs_an_nxt = an_enable && !en_r;
      rs_f_nxt = !an_enable;
    end
    // read data only in the cycle after a read of this register
    rdata_nxt = 16'h0000;
    if (rd_hit)
    begin
      rdata_nxt[`BIT_DISC_EN] = en_r;
      rdata_nxt[`BIT_POWER_FOUND] = pwr_r;
      rdata_nxt[`BIT_PLAIN_SEEN] = plain_r;
      rdata_nxt[`BIT_INHIBIT_LAPSED] = lapsed_r;
    end
  end

  // generator: taps x^11+x^9+1, nonzero seed loaded when empty
  always_comb
  begin
    if (lfsr_r == '0)
      lfsr_nxt = {{(LFSR_W-5){1'b0}}, port_addr | 5'h01}; // R24 R8
    else
      lfsr_nxt = {lfsr_r[LFSR_W-2:0], lfsr_r[10] ^ lfsr_r[8]}; // R24
  end

  // generator register, free running every cycle
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      lfsr_r <= '0;
    else
      lfsr_r <= lfsr_nxt;
  end

  // register all state except the generator
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= st_idle;
      snap_r <= '0;
      idx_r <= 3'd0;
      tog_r <= 1'b0;
      en_r <= 1'b0;
      pwr_r <= 1'b0;
      plain_r <= 1'b0;
      lapsed_r <= 1'b0;
      rdata_r <= 16'h0000;
      txp_r <= 16'h0000;
      txv_r <= 1'b0;
      adv_r <= 1'b0;
      rs_disc_r <= 1'b0;
      rs_an_r <= 1'b0;
      rs_f_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      snap_r <= snap_nxt;
      idx_r <= idx_nxt;
      tog_r <= tog_nxt;
      en_r <= en_nxt;
      pwr_r <= pwr_nxt;
      plain_r <= plain_nxt;
      lapsed_r <= lapsed_nxt;
      rdata_r <= rdata_nxt;
      txp_r <= txp_nxt;
      txv_r <= txv_nxt;
      adv_r <= adv_nxt;
      rs_disc_r <= rs_disc_nxt;
      rs_an_r <= rs_an_nxt;
      rs_f_r <= rs_f_nxt;
    end
  end

  // outputs straight from flip-flops
  assign mgmt_rdata = rdata_r;
  assign adv_np_able = adv_r;
  assign tx_page = txp_r;
  assign tx_page_valid = txv_r;
  assign restart_with_disc = rs_disc_r;
  assign restart_plain_an = rs_an_r;
  assign restart_forced = rs_f_r;
endmodule // dte_discovery
`default_nettype wire

//--- test/dte_discovery_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module dte_discovery_checker
(
  // watched ports
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic an_enable,
  input wire dte_disc_pkg::mgmt_s mgmt,
  input wire logic [15:0] mgmt_rdata,
  input wire logic adv_np_able,
  input wire logic [15:0] tx_page,
  input wire logic tx_page_valid,
  input wire logic restart_with_disc
);
  import dte_disc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  chk_idle_rdata_zero: assert property (!$past(mgmt.rd) |-> !mgmt_rdata)
    else $error("read data while idle");
  chk_rd_reserved: assert property (
    mgmt.rd |=> !(mgmt_rdata & 16'hFFA3))
    else $error("reserved bits set");
  chk_adv_needs_an: assert property (!an_enable |=> !adv_np_able)
    else $error("ability without negotiation");
  chk_page_np_ack: assert property (tx_page_valid |-> &tx_page[15:14])
    else $error("page bits 15 14");
  chk_page_bit12: assert property (tx_page_valid |-> !tx_page[12])
    else $error("page bit 12");
  chk_msg_code: assert property (
    tx_page_valid && tx_page[13] |-> tx_page[10:0] == 11'h005)
    else $error("message code");
  chk_toggle_flip: assert property (
    tx_page_valid && $past(tx_page_valid) && $changed(tx_page)
    |-> tx_page[11] != $past(tx_page[11]))
    else $error("toggle");
  chk_restart_pulse: assert property (
    restart_with_disc |=> !restart_with_disc)
    else $error("restart pulse");
endmodule // dte_discovery_checker
bind dte_discovery dte_discovery_checker i_chk (.sys_clk(sys_clk),
  .rstn(rstn), .an_enable(an_enable), .mgmt(mgmt), .mgmt_rdata(mgmt_rdata),
  .adv_np_able(adv_np_able), .tx_page(tx_page),
  .tx_page_valid(tx_page_valid), .restart_with_disc(restart_with_disc));
`default_nettype wire

//--- test/link_partner_model.sv
`timescale 1ns/100ps
`default_nettype none
module link_partner_model
(
  // link side
  input wire logic sys_clk,
  input wire logic [15:0] tx_page,
  input wire logic tx_page_valid,
  input wire logic corrupt,
  input wire logic [3:0] dly,
  output var dte_disc_pkg::page_s rx_page
);
  import dte_disc_pkg::*;
  logic [15:0] last = '0;
  initial rx_page = '0;
  // echo each fresh page after a delay
  always @(posedge sys_clk)
  begin
    if (!tx_page_valid)
      last = '0;
    else if (tx_page !== last)
    begin
      last = tx_page;
      repeat (dly) @(posedge sys_clk);
      @(negedge sys_clk);
      rx_page = {1'b1, tx_page ^ {15'h0, corrupt}};
      @(negedge sys_clk);
      rx_page = '0;
    end
  end
endmodule // link_partner_model
`default_nettype wire

//--- test/remote_power_dte_discovery_test.sv
`timescale 1ns/100ps
`default_nettype none
module remote_power_dte_discovery_test;
  import dte_disc_pkg::*;
  logic sys_clk = 0, rstn = 0, an_en = 1, np = 0, bad = 0;
  logic [3:0] dly = 0;
  logic [2:0] rs = 0;
  logic [21:0] s;
  logic [15:0] id2, id3, rdata, txp, pg;
  logic [31:0] x = 32'hB4DF;
  logic adv, txv, r_d, r_p, r_f;
  line_act_e act = act_none;
  page_s rxp;
  an_evt_s evt = '0;
  mgmt_s mgmt = '0;
  int miscompares = 0, cmp_count = 0;
  logic [15:0] sq[$], eq[5];
  logic [10:0] m = 0, sm = 0;
  logic pwr_on = 0;
  always #5 sys_clk = ~sys_clk;
  dte_discovery i_dte_discovery (.sys_clk(sys_clk), .rstn(rstn),
    .port_addr(x[20:16]), .phy_id2(id2), .phy_id3(id3), .an_enable(an_en),
    .line_act(act), .partner_np_able(np), .rx_page(rxp),
    .tx_page_taken(1'b0), .an_evt(evt), .mgmt(mgmt), .mgmt_rdata(rdata),
    .adv_np_able(adv), .tx_page(txp), .tx_page_valid(txv),
    .restart_with_disc(r_d), .restart_plain_an(r_p), .restart_forced(r_f));
  link_partner_model i_link_partner_model (.sys_clk(sys_clk), .tx_page(txp),
    .tx_page_valid(txv), .corrupt(bad), .dly(dly), .rx_page(rxp));
  // record sent pages and restart pulses
  always @(negedge sys_clk)
  begin
    if (txv && (sq.size() == 0 || sq[$] !== txp))
      sq.push_back(txp);
    rs |= {r_f, r_p, r_d};
  end
  // generator model: nonzero seed from port address, one step per cycle
  always @(posedge sys_clk)
  begin
    if (act == act_flp && np)
      sm <= m;
    if (!rstn)
      m <= '0;
    else if (m == '0)
      m <= {6'h00, x[20:16] | 5'h01};
    else
      m <= {m[9:0], m[10] ^ m[8]};
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic check(input string n, input logic [15:0] seen, e);
    cmp_count++;
    if (seen !== e)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    mgmt = {w, ~w, a, d};
    @(negedge sys_clk);
    mgmt = '0;
    pg = rdata;
  endtask
  task automatic rd(input logic [15:0] e);
    acc(0, 5'h1B, 0);
    check("status", pg, e);
  endtask
  task automatic ev(input logic [4:0] e);
    @(negedge sys_clk);
    evt = e;
    @(negedge sys_clk);
    evt = '0;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic go(input logic b, input logic [3:0] d);
    sq = {};
    bad = b;
    dly = d;
    @(negedge sys_clk);
    act = act_flp;
    np = 1;
    @(negedge sys_clk);
    act = act_none;
    np = 0;
    repeat (60) @(negedge sys_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    x = xs(x);
    id2 = x[15:0];
    id3 = x[31:16];
    s = {id2, id3[15:10]};
    repeat (2) @(negedge sys_clk);
    rstn = 1;
    rd(16'h0000);
    acc(1, 5'h07, x[15:0]);
    acc(1, 5'h1B, 16'hFFFF);
    rd(16'h0040);
    acc(0, 5'h07, 0);
    check("unmapped", pg, 16'h0000);
    check("adv", {15'h0, adv}, 16'h0001);
    go(0, 0);
    eq[0] = 16'hE005;
    eq[1] = 16'hC800;
    eq[2] = 16'hC000;
    eq[3] = {7'h64, sm[8:0]};
    eq[4] = {5'h18, sm};
    for (int j = 0; j < 11; j++)
    begin
      eq[1][10-j] = s[j];
      eq[2][10-j] = s[11+j];
    end
    for (int i = 0; i < 3; i++)
      check("page", sq[i], eq[i]);
    check("page3", sq[3], eq[3]);
    check("page4", sq[4], eq[4]);
    check("random", sq[3][8:0], sq[4][8:0]);
    rd(16'h0050);
    check("held", txp, sq[4]);
    pwr_on = pg[4];
    if (pwr_on)
      ev(5'h10);
    rd(16'h0040);
    // no link came up in the wait: cable power goes off again
    pwr_on = 1'b0;
    go(1, 5);
    rd(16'h0048);
    rd(16'h0040);
    ev(5'h01);
    rd(16'h0044);
    an_en = 0;
    ev(5'h01);
    an_en = 1;
    acc(1, 5'h1B, 0);
    ev(5'h01);
    check("restarts", rs, 3'h7);
    report_and_stop;
  end
  // hang guard
  initial
  begin
    #20000;
    miscompares++;
    report_and_stop;
  end
endmodule // remote_power_dte_discovery_test
`default_nettype wire
